// ==== pkg/eq_config_pkg.sv ====
// Purpose: Shared constants of the serial pre-emphasis and equalizer loader
// Assumes: One 10 MHz clock, the serial pins are asynchronous to it
// Notes:   Word bits are the four level bits followed by the equalizer bit
package eq_config_pkg;

    localparam int          WORD_BITS      = 5;
    localparam int          CODE_BITS      = 4;
    localparam int          CODE_LSB       = 1;
    localparam int          EQ_BIT         = 0;
    localparam int          SYNC_STAGES    = 2;
    localparam int          PIN_COUNT      = 3;
    localparam int          PIN_DATA       = 0;
    localparam int          PIN_CLOCK      = 1;
    localparam int          PIN_LOAD       = 2;

    localparam int          ADDR_BITS      = 8;
    localparam int          DATA_BITS      = 32;
    localparam int          COUNT_BITS     = 16;

    localparam logic [7:0]  OFFS_CONTROL   = 8'h00;
    localparam logic [7:0]  OFFS_STATUS    = 8'h04;
    localparam logic [7:0]  OFFS_EDGES     = 8'h08;

    localparam int          CTRL_SHIFT_EN  = 0;
    localparam int          CTRL_CLR_EDGES = 1;
    localparam logic        CTRL_SHIFT_RST = 1'b1;

    localparam int          STAT_WORD_LSB  = 0;
    localparam int          STAT_SET_LSB   = 5;
    localparam int          STAT_LOAD      = 10;
    localparam int          STAT_SCLK      = 11;

    localparam logic [4:0]  SETTING_RESET  = 5'h00;

    localparam int          CLK_HZ         = 10_000_000;
    localparam int          SCLK_MAX_HZ    = 20_000_000;
    localparam int          LOAD_MIN_NS    = 6;
    localparam int          LOAD_MIN_CYC   =
        ((LOAD_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000 < 1) ? 1 :
        (LOAD_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

endpackage : eq_config_pkg

// ==== pkg/shift_if.sv ====
// Purpose: Link between the loader top and its serial shift stage
// Assumes: All signals on the one system clock
// Notes:   The shift stage answers a shift request on the next edge
interface shift_if;
    import eq_config_pkg::*;

    logic                  shift_en;
    logic                  serial_bit;
    logic [WORD_BITS-1:0]  word;
    logic                  chain_bit;

    modport ctrl
    (
        output shift_en,
        output serial_bit,
        input  word,
        input  chain_bit
    );

    modport stage
    (
        input  shift_en,
        input  serial_bit,
        output word,
        output chain_bit
    );

endinterface : shift_if

// ==== verification/serial_host_model.sv ====
// Purpose: Host controller model driving the serial configuration pins
// Assumes: Paced by the system clock, half serial period of four cycles
// Notes:   Data and clock pins rest low between frames, as the pad pull-downs leave them
module serial_host_model
    import eq_config_pkg::*;
(
    input  wire logic clk,
    output logic      sdata,
    output logic      sclk,
    output logic      load
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF_CYC = 4;

    initial
    begin
        sdata = 1'b0;
        sclk  = 1'b0;
        load  = 1'b0;
    end

    // 800 ns serial period: four cycles low, four high
    task automatic send_bit(input logic b);
        @(posedge clk);
        sdata <= b;
        repeat (HALF_CYC - 1) @(posedge clk);
        sclk <= 1'b1;
        repeat (HALF_CYC) @(posedge clk);
        sclk  <= 1'b0;
        sdata <= 1'b0;
    endtask : send_bit

    task automatic send_word(input logic [WORD_BITS-1:0] w);
        for (int i = WORD_BITS - 1; i >= 0; i--)
            send_bit(w[i]);
        // Let the last fall pass the synchroniser before anything else
        repeat (HALF_CYC) @(posedge clk);
    endtask : send_word

    task automatic set_load(input logic v);
        @(posedge clk);
        load <= v;
        repeat (HALF_CYC) @(posedge clk);
    endtask : set_load
endmodule : serial_host_model

// ==== verification/test_serial_eq_preemph_config.sv ====
// Purpose: Self-checking bench of the serial pre-emphasis loader
// Assumes: Host model drives the serial pins, bench drives the register port
// Notes:   Driver queues expectations, a monitor compares them in order
module test_serial_eq_preemph_config
    import eq_config_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic                 look = 1'b0, rd_flag = 1'b0, prev_cclk = 1'b0;
    logic [1:0]           look_sel = 2'h0;
    logic [ADDR_BITS-1:0] reg_addr = 8'h00;
    logic [DATA_BITS-1:0] reg_wdata = 32'h0, reg_rdata;
    logic                 sdata, sclk, load, chain_data, chain_clock, eq_en, eq_byp;
    logic [CODE_BITS-1:0] code;
    logic [31:0]          exp_q[$];
    logic                 hist[$];
    logic [7:0]           lfsr = 8'h03;
    logic [WORD_BITS-1:0] w, wlast;
    int                   n_mismatch = 0, total_checks = 0, n_cclk = 0, base;

    always #50 clk = ~clk;

    serial_host_model serial_host_model_i (.clk(clk), .sdata(sdata), .sclk(sclk), .load(load));
    eq_config_loader eq_config_loader_i (.CLK(clk), .RST(rst), .SERIAL_DATA_IN(sdata),
        .SERIAL_CLOCK_IN(sclk), .CONFIG_LATCH_LOAD(load), .CHAIN_DATA_OUT(chain_data),
        .CHAIN_CLOCK_OUT(chain_clock), .PREEMPHASIS_CODE(code), .EQUALIZER_ENABLE(eq_en),
        .EQUALIZER_BYPASS(eq_byp), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    function automatic logic [31:0] set_of(input logic [WORD_BITS-1:0] v);
        return {26'h0, ~v[0], v};
    endfunction : set_of

    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        total_checks++;
        if (seen !== expd)
        begin
            n_mismatch++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, expd);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : reg_read

    // Select 1 setting, 2 chain data, 3 chain clock rises
    task automatic expect_val(input logic [1:0] sel, input logic [31:0] v);
        @(posedge clk);
        exp_q.push_back(v);
        look_sel <= sel;
        look     <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
    endtask : expect_val

    always @(posedge clk)
    begin
        rd_flag   <= reg_rd;
        prev_cclk <= chain_clock;
        if (chain_clock === 1'b1 && prev_cclk === 1'b0)
            n_cclk <= n_cclk + 1;
    end

    always @(negedge clk)
    begin
        if (rd_flag === 1'b1 || look === 1'b1)
            check(rd_flag === 1'b1 ? reg_rdata : look_sel == 2'h1 ? {26'h0, eq_byp, code, eq_en}
                : look_sel == 2'h2 ? {31'h0, chain_data} : 32'(n_cclk),
                exp_q.size() > 0 ? exp_q.pop_front() : 32'hx);
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        expect_val(2'h1, set_of(5'h00));
        reg_read(OFFS_CONTROL, 32'h1);
        reg_read(8'h0c, 32'h0);
        reg_write(8'h10, 32'hffff_ffff);
        reg_read(OFFS_CONTROL, 32'h1);
        reg_write(OFFS_CONTROL, 32'h3);
        for (int i = 0; i < 16; i++)
        begin
            lfsr = lfsr_next(lfsr);
            w = {4'(i), lfsr[0]};
            serial_host_model_i.send_word(w);
            expect_val(2'h1, set_of(w));
        end
        reg_read(OFFS_EDGES, 32'h0000_0050);
        wlast = w;
        serial_host_model_i.set_load(1'b1);
        w = ~wlast;
        serial_host_model_i.send_word(w);
        expect_val(2'h1, set_of(wlast));
        reg_read(OFFS_STATUS, {20'h0, 2'b01, wlast, w});
        serial_host_model_i.set_load(1'b0);
        expect_val(2'h1, set_of(w));
        reg_write(OFFS_CONTROL, 32'h0);
        serial_host_model_i.send_word(~w);
        reg_read(OFFS_STATUS, {20'h0, 2'b00, w, w});
        reg_write(OFFS_CONTROL, 32'h1);
        for (int i = WORD_BITS - 1; i >= 0; i--)
            hist.push_back(w[i]);
        base = n_cclk;
        for (int i = 0; i < 12; i++)
        begin
            lfsr = lfsr_next(lfsr);
            hist.push_back(lfsr[0]);
            serial_host_model_i.send_bit(lfsr[0]);
            expect_val(2'h2, {31'h0, hist[hist.size() - 6]});
        end
        expect_val(2'h3, 32'(base + 12));
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        expect_val(2'h1, set_of(5'h00));
        repeat (4) @(posedge clk);
        report_and_stop();
    end
endmodule : test_serial_eq_preemph_config

// ==== verilog/eq_config_loader.sv ====
// Purpose: Serial loader of the pre-emphasis level and equalizer enable
// Assumes: Serial pins are asynchronous; serial clock far slower than CLK
// Notes:   Setting is transparent while the load pin is low, frozen while high
module eq_config_loader
    import eq_config_pkg::*;
(
    input  wire logic                 CLK,
    input  wire logic                 RST,
    input  wire logic                 SERIAL_DATA_IN,
    input  wire logic                 SERIAL_CLOCK_IN,
    input  wire logic                 CONFIG_LATCH_LOAD,
    output logic                      CHAIN_DATA_OUT,
    output logic                      CHAIN_CLOCK_OUT,
    output logic [CODE_BITS-1:0]      PREEMPHASIS_CODE,
    output logic                      EQUALIZER_ENABLE,
    output logic                      EQUALIZER_BYPASS,
    input  wire logic [ADDR_BITS-1:0] REG_ADDR,
    input  wire logic [DATA_BITS-1:0] REG_WDATA,
    input  wire logic                 REG_WR,
    input  wire logic                 REG_RD,
    output logic      [DATA_BITS-1:0] REG_RDATA
);

    typedef struct packed
    {
        logic                  sclk_prev;
        logic                  chain_clock;
        logic [WORD_BITS-1:0]  setting;
        logic                  shift_enable;
        logic [COUNT_BITS-1:0] edge_count;
        logic [DATA_BITS-1:0]  rdata;
    } loader_state_t;

    function automatic logic [CODE_BITS-1:0] level_select_bits
    (
        input logic [WORD_BITS-1:0] w
    );
        level_select_bits = w[CODE_LSB +: CODE_BITS];
    endfunction : level_select_bits

    function automatic logic eq_bit
    (
        input logic [WORD_BITS-1:0] w
    );
        eq_bit = w[EQ_BIT];
    endfunction : eq_bit

    loader_state_t        state;
    loader_state_t        next_state;
    logic [PIN_COUNT-1:0] pins_raw;
    logic [PIN_COUNT-1:0] pins;
    logic                 data_s;
    logic                 sclk_s;
    logic                 load_s;
    logic                 sclk_rise;
    logic [DATA_BITS-1:0] status_word;

    shift_if link ();

    // Open pins are pulled low at the pad; a low level is the idle value
    assign pins_raw[PIN_DATA]  = SERIAL_DATA_IN;
    assign pins_raw[PIN_CLOCK] = SERIAL_CLOCK_IN;
    assign pins_raw[PIN_LOAD]  = CONFIG_LATCH_LOAD;

    pin_sync #(
        .WIDTH  (PIN_COUNT)
    ) pin_sync_i (
        .clk    (CLK),
        .rst    (RST),
        .pins   (pins_raw),
        .synced (pins)
    );

    assign data_s    = pins[PIN_DATA];
    assign sclk_s    = pins[PIN_CLOCK];
    assign load_s    = pins[PIN_LOAD];
    assign sclk_rise = sclk_s & ~state.sclk_prev;

    // One shift per serial clock rise while shifting is enabled, top bit arrives first
    assign link.shift_en   = sclk_rise & state.shift_enable;
    assign link.serial_bit = data_s;

    serial_shifter serial_shifter_i (
        .clk  (CLK),
        .rst  (RST),
        .link (link.stage)
    );

    always_comb
    begin
        status_word                                = '0;
        status_word[STAT_WORD_LSB +: WORD_BITS]    = link.word;
        status_word[STAT_SET_LSB +: WORD_BITS]     = state.setting;
        status_word[STAT_LOAD]                     = load_s;
        status_word[STAT_SCLK]                     = sclk_s;
    end

    always_comb
    begin
        next_state             = state;
        next_state.sclk_prev   = sclk_s;
        // Clock leaves in the same cycle as the shifted data
        next_state.chain_clock = sclk_s;

        // Latch transparent while low, holding while high
        if (!load_s)
        begin
            next_state.setting = link.word;
        end
        else
        begin
            next_state.setting = state.setting;
        end

        if (sclk_rise)
        begin
            next_state.edge_count = state.edge_count + 1'b1;
        end

        if (REG_WR && REG_ADDR == OFFS_CONTROL)
        begin
            next_state.shift_enable = REG_WDATA[CTRL_SHIFT_EN];
            if (REG_WDATA[CTRL_CLR_EDGES])
            begin
                // A rise in the same cycle still counts
                next_state.edge_count = COUNT_BITS'(sclk_rise);
            end
        end

        next_state.rdata = '0;
        if (REG_RD)
        begin
            if (REG_ADDR == OFFS_CONTROL)
            begin
                next_state.rdata[CTRL_SHIFT_EN] = state.shift_enable;
            end
            else if (REG_ADDR == OFFS_STATUS)
            begin
                next_state.rdata = status_word;
            end
            else if (REG_ADDR == OFFS_EDGES)
            begin
                next_state.rdata[COUNT_BITS-1:0] = state.edge_count;
            end
            else
            begin
                next_state.rdata = '0;
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            state              <= '0;
            state.setting      <= SETTING_RESET;
            state.shift_enable <= CTRL_SHIFT_RST;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign CHAIN_DATA_OUT   = link.chain_bit;
    assign CHAIN_CLOCK_OUT  = state.chain_clock;
    assign PREEMPHASIS_CODE = level_select_bits(state.setting);
    assign EQUALIZER_ENABLE = eq_bit(state.setting);
    assign EQUALIZER_BYPASS = ~eq_bit(state.setting);
    assign REG_RDATA        = state.rdata;

    // Checks

    a_shift_on_rise: assert property (@(posedge CLK) disable iff (RST)
        link.shift_en |=> link.word == {$past(link.word[WORD_BITS-2:0]), $past(data_s)})
        else $error("shift word did not advance on serial clock rise");

    a_shift_idle: assert property (@(posedge CLK) disable iff (RST)
        !link.shift_en |=> $stable(link.word))
        else $error("shift word changed without a serial clock rise");

    a_chain_delay: assert property (@(posedge CLK) disable iff (RST)
        link.shift_en |=> CHAIN_DATA_OUT == $past(link.word[WORD_BITS-1]))
        else $error("chain data is not the bit five shifts old");

    a_chain_clock: assert property (@(posedge CLK) disable iff (RST)
        sclk_rise |=> CHAIN_CLOCK_OUT && $rose(CHAIN_CLOCK_OUT))
        else $error("chain clock did not follow the serial clock rise");

    a_load_open: assert property (@(posedge CLK) disable iff (RST)
        !load_s |=> PREEMPHASIS_CODE == $past(link.word[CODE_LSB +: CODE_BITS])
                    && EQUALIZER_ENABLE == $past(link.word[EQ_BIT]))
        else $error("setting not transparent while load is low");

    a_load_hold: assert property (@(posedge CLK) disable iff (RST)
        load_s [*2] |=> $stable(PREEMPHASIS_CODE) && $stable(EQUALIZER_ENABLE))
        else $error("setting moved while load is high");

    a_eq_route: assert property (@(posedge CLK) disable iff (RST)
        EQUALIZER_BYPASS != EQUALIZER_ENABLE)
        else $error("equalizer bypass and enable agree");

    a_start_default: assert property (@(posedge CLK)
        RST |=> PREEMPHASIS_CODE == '0 && !EQUALIZER_ENABLE && !CHAIN_DATA_OUT)
        else $error("start-up setting is not 0 dB with equalizer off");

    a_level_field: assert property (@(posedge CLK) disable iff (RST)
        $past(!load_s) && !load_s |=>
            {PREEMPHASIS_CODE, EQUALIZER_ENABLE} == $past(link.word))
        else $error("level and enable bits taken from wrong word positions");

    a_status_read: assert property (@(posedge CLK) disable iff (RST)
        REG_RD && REG_ADDR == OFFS_STATUS |=>
            REG_RDATA[STAT_SET_LSB +: WORD_BITS] == $past(state.setting)
            && REG_RDATA[STAT_SET_LSB] == $past(EQUALIZER_ENABLE))
        else $error("status read does not show the held setting");

    a_bypass_open: assert property (@(posedge CLK) disable iff (RST)
        !load_s |=> EQUALIZER_BYPASS == !$past(link.word[EQ_BIT]))
        else $error("bypass does not follow the enable bit while load is low");

    a_bypass_hold: assert property (@(posedge CLK) disable iff (RST)
        load_s [*2] |=> $stable(EQUALIZER_BYPASS))
        else $error("bypass moved while load is high");

    a_chain_follow: assert property (@(posedge CLK) disable iff (RST)
        1'b1 |=> CHAIN_CLOCK_OUT == $past(sclk_s))
        else $error("chain clock does not repeat the synced serial clock");

    a_chain_fall: assert property (@(posedge CLK) disable iff (RST)
        $fell(sclk_s) |=> !CHAIN_CLOCK_OUT)
        else $error("chain clock stayed high after the serial clock fell");

    a_chain_hold: assert property (@(posedge CLK) disable iff (RST)
        !link.shift_en |=> $stable(CHAIN_DATA_OUT))
        else $error("chain data changed without a shift");

    a_shift_frozen: assert property (@(posedge CLK) disable iff (RST)
        sclk_rise && !state.shift_enable |=> $stable(link.word))
        else $error("shift word moved while shifting is disabled");

    a_rise_needed: assert property (@(posedge CLK) disable iff (RST)
        link.shift_en |-> sclk_s && !$past(sclk_s))
        else $error("shift requested without a serial clock rise");

    a_count_rise: assert property (@(posedge CLK) disable iff (RST)
        sclk_rise && !(REG_WR && REG_ADDR == OFFS_CONTROL && REG_WDATA[CTRL_CLR_EDGES]) |=>
            state.edge_count == $past(state.edge_count) + 1'b1)
        else $error("serial clock rise was not counted");

    a_count_clear: assert property (@(posedge CLK) disable iff (RST)
        REG_WR && REG_ADDR == OFFS_CONTROL && REG_WDATA[CTRL_CLR_EDGES] |=>
            state.edge_count == COUNT_BITS'($past(sclk_rise)))
        else $error("edge count clear lost a rise in the same cycle");

    a_pin_delay: assert property (@(posedge CLK) disable iff (RST)
        !$past(RST) && !$past(RST, 2) |->
            {data_s, sclk_s, load_s} == {$past(SERIAL_DATA_IN, 2), $past(SERIAL_CLOCK_IN, 2),
                                         $past(CONFIG_LATCH_LOAD, 2)})
        else $error("pin did not reach the logic two clocks after it changed");

    a_start_route: assert property (@(posedge CLK)
        RST |=> EQUALIZER_BYPASS && !CHAIN_CLOCK_OUT && REG_RDATA == '0)
        else $error("start-up leaves the equalizer routed or a chain pin high");

    a_word_read: assert property (@(posedge CLK) disable iff (RST)
        REG_RD && REG_ADDR == OFFS_STATUS |=>
            REG_RDATA[STAT_WORD_LSB +: WORD_BITS] == $past(link.word))
        else $error("status read does not show the five-bit shift word");

    a_edges_read: assert property (@(posedge CLK) disable iff (RST)
        REG_RD && REG_ADDR == OFFS_EDGES |=>
            REG_RDATA[COUNT_BITS-1:0] == $past(state.edge_count))
        else $error("edge count read does not match the counter");

    a_ctrl_write: assert property (@(posedge CLK) disable iff (RST)
        REG_WR && REG_ADDR == OFFS_CONTROL |=>
            state.shift_enable == $past(REG_WDATA[CTRL_SHIFT_EN]))
        else $error("control write did not set the shift enable");

    a_ctrl_read: assert property (@(posedge CLK) disable iff (RST)
        REG_RD && REG_ADDR == OFFS_CONTROL |=>
            REG_RDATA == DATA_BITS'($past(state.shift_enable)))
        else $error("control read does not show the shift enable");

    a_read_idle: assert property (@(posedge CLK) disable iff (RST)
        !REG_RD |=> REG_RDATA == '0)
        else $error("read data present without a read strobe");

    a_read_unmapped: assert property (@(posedge CLK) disable iff (RST)
        REG_RD && REG_ADDR != OFFS_CONTROL && REG_ADDR != OFFS_STATUS
            && REG_ADDR != OFFS_EDGES |=> REG_RDATA == '0)
        else $error("read of an unused address returned data");

    a_status_pins: assert property (@(posedge CLK) disable iff (RST)
        REG_RD && REG_ADDR == OFFS_STATUS |=>
            REG_RDATA[STAT_LOAD] == $past(load_s) && REG_RDATA[STAT_SCLK] == $past(sclk_s))
        else $error("status read does not show the synced load and clock pins");

endmodule : eq_config_loader

// ==== verilog/pin_sync.sv ====
// Purpose: Two-flop synchroniser for a group of asynchronous pins
// Assumes: Synchronous active-high reset
// Notes:   Only the second stage is visible outside
module pin_sync
    import eq_config_pkg::*;
#(
    parameter int WIDTH = PIN_COUNT
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pins,
    output logic      [WIDTH-1:0] synced
);

    typedef struct packed
    {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    always_comb
    begin
        next_state        = state;
        next_state.meta   = pins;
        next_state.stable = state.meta;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign synced = state.stable;

endmodule : pin_sync

// ==== verilog/serial_shifter.sv ====
// Purpose: Five-stage serial shift register with a chained output stage
// Assumes: One shift request per detected serial clock rise
// Notes:   Chain bit takes the oldest bit before the shift, so it lags 5 shifts
module serial_shifter
    import eq_config_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    shift_if.stage    link
);

    typedef struct packed
    {
        logic [WORD_BITS-1:0] word;
        logic                 chain_bit;
    } shifter_state_t;

    shifter_state_t state;
    shifter_state_t next_state;

    always_comb
    begin
        next_state = state;
        if (link.shift_en)
        begin
            // Oldest bit leaves toward the next device
            next_state.chain_bit = state.word[WORD_BITS-1];
            next_state.word      = {state.word[WORD_BITS-2:0], link.serial_bit};
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign link.word      = state.word;
    assign link.chain_bit = state.chain_bit;

endmodule : serial_shifter
